// File: design/cime_exec.sv
// Executor for increment, OR, pointer load, bank load and move instructions
`default_nettype none

module cime_exec
	import cime_pkg::*;
#(
	parameter int PTR_N = CIME_PTR_N
) (
	// Clock and reset
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	// Instruction stream
	input  wire logic                  instr_valid_i,
	input  wire logic [15:0]           instr_i,
	output logic                       instr_ready_o,
	// Data memory
	output logic      [11:0]           mem_addr_o,
	output logic                       mem_rd_o,
	input  wire logic [7:0]            mem_rd_data_i,
	output logic                       mem_wr_o,
	output logic      [7:0]            mem_wr_data_o,
	// Core state
	output logic      [7:0]            wreg_o,
	output logic      [7:0]            bank_o,
	output cime_flags_t                status_o,
	output logic      [PTR_N*12-1:0]   ptr_o,
	// Progress
	output logic                       discard_o,
	output logic                       done_o
);

	cime_state_t state_r, state_nxt;
	cime_op_t    op_r, op_in;
	logic [15:0] ir_r;
	logic        skip_r, cap_r, acc, go;
	logic [7:0]  ff_data_r, ff_val, alu_res;
	cime_flags_t alu_flags;
	logic [11:0] ptr_r [PTR_N];

	assign op_in = cime_decode(instr_i);
	assign acc   = instr_valid_i && instr_ready_o;
	// Taken word that really executes (not a skipped one)
	assign go    = acc && (state_r == CIME_S_FETCH) && !skip_r;
	// Memory answers one cycle after the read strobe
	assign ff_val = cap_r ? mem_rd_data_i : ff_data_r;

	cime_alu u_alu (
		.op_i    (op_r),
		.w_i     (wreg_o),
		.f_i     (mem_rd_data_i),
		.res_o   (alu_res),
		.flags_o (alu_flags)
	);

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			CIME_S_FETCH: begin
				if (go) begin
					case (op_in)
						CIME_OP_INC, CIME_OP_INCSZ, CIME_OP_INSNZ, CIME_OP_ORF,
						CIME_OP_FMOVE: state_nxt = CIME_S_READ;
						CIME_OP_PTRLD: state_nxt = CIME_S_WORD2;
						CIME_OP_F2F:   state_nxt = CIME_S_FFRD;
						default:       state_nxt = CIME_S_FETCH;
					endcase
				end
			end
			CIME_S_READ:  state_nxt = CIME_S_EXEC;
			CIME_S_EXEC:  state_nxt = CIME_S_FETCH;
			CIME_S_FFRD:  state_nxt = CIME_S_WORD2;
			CIME_S_WORD2: begin
				if (acc)
					state_nxt = (op_r == CIME_OP_F2F) ? CIME_S_FFWR : CIME_S_FETCH;
			end
			CIME_S_FFWR:  state_nxt = CIME_S_FETCH;
			default:      state_nxt = CIME_S_FETCH;
		endcase
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_r       <= CIME_S_FETCH;
			instr_ready_o <= 1'b0;
		end else begin
			state_r       <= state_nxt;
			instr_ready_o <= (state_nxt == CIME_S_FETCH) || (state_nxt == CIME_S_WORD2);
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ir_r <= 16'h0000;
			op_r <= CIME_OP_NOP;
		end else if (acc && state_r == CIME_S_FETCH) begin
			ir_r <= instr_i;
			op_r <= skip_r ? CIME_OP_NOP : op_in;
		end
	end

	// ----------------------------------------------------------------
	// Skip and discard of prefetched words
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			skip_r <= 1'b0;
		end else if (state_r == CIME_S_EXEC &&
			((op_r == CIME_OP_INCSZ && alu_flags.z) ||
			(op_r == CIME_OP_INSNZ && !alu_flags.z))) begin
			skip_r <= 1'b1; // [RULE3]
		end else if (acc && state_r == CIME_S_FETCH && skip_r) begin
			// A long instruction keeps the skip alive for its second word
			skip_r <= cime_is_long(instr_i); // [RULE3] [RULE8]
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			discard_o <= 1'b0;
			done_o    <= 1'b0;
		end else begin
			discard_o <= acc && state_r == CIME_S_FETCH && skip_r; // [RULE3]
			done_o    <= (acc && state_r == CIME_S_FETCH && state_nxt == CIME_S_FETCH) ||
				state_r == CIME_S_EXEC || state_r == CIME_S_FFWR ||
				(acc && state_r == CIME_S_WORD2 && op_r == CIME_OP_PTRLD);
		end
	end

	// ----------------------------------------------------------------
	// Data memory port
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			mem_addr_o    <= 12'h000;
			mem_rd_o      <= 1'b0;
			mem_wr_o      <= 1'b0;
			mem_wr_data_o <= 8'h00;
		end else begin
			mem_rd_o <= 1'b0;
			mem_wr_o <= 1'b0;
			if (go) begin
				case (op_in)
					CIME_OP_INC, CIME_OP_INCSZ, CIME_OP_INSNZ, CIME_OP_ORF,
					CIME_OP_FMOVE: begin
						mem_rd_o   <= 1'b1;
						mem_addr_o <= cime_file_addr(instr_i, bank_o); // [RULE2]
					end
					CIME_OP_WSTORE: begin
						mem_wr_o      <= 1'b1; // [RULE13]
						mem_addr_o    <= cime_file_addr(instr_i, bank_o); // [RULE2]
						mem_wr_data_o <= wreg_o;
					end
					CIME_OP_F2F: begin
						mem_rd_o   <= 1'b1; // [RULE8]
						mem_addr_o <= instr_i[11:0]; // [RULE7]
					end
					default: ;
				endcase
			end else if (state_r == CIME_S_EXEC && ir_r[CIME_D_BIT]) begin
				mem_wr_o      <= 1'b1; // [RULE1] [RULE6] [RULE12]
				mem_wr_data_o <= alu_res;
			end else if (acc && state_r == CIME_S_WORD2 && op_r == CIME_OP_F2F) begin
				mem_rd_o      <= 1'b1; // [RULE8]
				mem_addr_o    <= instr_i[11:0]; // [RULE7]
				mem_wr_data_o <= ff_val;
			end else if (state_r == CIME_S_FFWR) begin
				mem_wr_o <= 1'b1; // [RULE8]
			end
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cap_r     <= 1'b0;
			ff_data_r <= 8'h00;
		end else begin
			cap_r <= (state_r == CIME_S_FFRD);
			if (cap_r)
				ff_data_r <= mem_rd_data_i;
		end
	end

	// ----------------------------------------------------------------
	// Working register, bank select and status
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wreg_o   <= 8'h00;
			bank_o   <= 8'h00;
			status_o <= '0;
		end else if (go) begin
			case (op_in)
				CIME_OP_ORL: begin
					wreg_o     <= wreg_o | instr_i[7:0]; // [RULE12]
					status_o.n <= instr_i[7] | wreg_o[7];
					status_o.z <= (wreg_o | instr_i[7:0]) == 8'h00;
				end
				CIME_OP_LITW:   wreg_o <= instr_i[7:0]; // [RULE13]
				CIME_OP_BANKLD: bank_o <= instr_i[7:0]; // [RULE11]
				default: ;
			endcase
		end else if (state_r == CIME_S_EXEC) begin
			if (!ir_r[CIME_D_BIT])
				wreg_o <= alu_res; // [RULE1] [RULE6] [RULE12]
			case (op_r)
				CIME_OP_INC: status_o <= alu_flags; // [RULE1]
				CIME_OP_ORF, CIME_OP_FMOVE: begin
					status_o.n <= alu_flags.n; // [RULE6] [RULE12]
					status_o.z <= alu_flags.z;
				end
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Indirect pointers
	// ----------------------------------------------------------------
	for (genvar g = 0; g < PTR_N; g++) begin : g_ptr
		always_ff @(posedge clk_i or posedge rst_i) begin
			if (rst_i) begin
				ptr_r[g] <= 12'h000;
			end else if (go && op_in == CIME_OP_PTRLD && instr_i[5:4] == 2'(g)) begin
				ptr_r[g][11:8] <= instr_i[3:0]; // [RULE4]
			end else if (acc && state_r == CIME_S_WORD2 && op_r == CIME_OP_PTRLD &&
				ir_r[5:4] == 2'(g)) begin
				ptr_r[g][7:0] <= instr_i[7:0]; // [RULE5]
			end
		end
		assign ptr_o[g*12 +: 12] = ptr_r[g];
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_ff_first;
		go && op_in == CIME_OP_F2F;
	endsequence

	sequence s_ff_second;
		acc && state_r == CIME_S_WORD2 && op_r == CIME_OP_F2F;
	endsequence

	a_inc_write: assert property ( // [RULE1]
		(state_r == CIME_S_EXEC && op_r == CIME_OP_INC && ir_r[CIME_D_BIT]) |=>
		mem_wr_o && mem_wr_data_o == 8'($past(mem_rd_data_i) + 8'h01))
		else $error("increment result not written back");
	a_bank_addr: assert property ( // [RULE2]
		(go && op_in == CIME_OP_FMOVE) |=> mem_rd_o &&
		mem_addr_o == ($past(instr_i[CIME_A_BIT]) ? {$past(bank_o[3:0]), $past(instr_i[7:0])}
		: {($past(instr_i[7]) ? CIME_ACC_HI_BANK : CIME_ACC_LO_BANK), $past(instr_i[7:0])}))
		else $error("file address bank wrong");
	a_skip_drop: assert property ( // [RULE3]
		(acc && state_r == CIME_S_FETCH && skip_r) |=> discard_o && !mem_rd_o && !mem_wr_o)
		else $error("skipped word not discarded");
	a_ptr_high: assert property ( // [RULE4]
		(go && op_in == CIME_OP_PTRLD && instr_i[5:4] == 2'd0) |=>
		ptr_o[11:8] == $past(instr_i[3:0]) && state_r == CIME_S_WORD2)
		else $error("pointer high byte not loaded");
	a_ptr_low: assert property ( // [RULE5]
		(acc && state_r == CIME_S_WORD2 && op_r == CIME_OP_PTRLD && ir_r[5:4] == 2'd0) |=>
		ptr_o[7:0] == $past(instr_i[7:0]) && done_o)
		else $error("pointer low byte not loaded");
	a_move_flags: assert property ( // [RULE6]
		(state_r == CIME_S_EXEC && op_r == CIME_OP_FMOVE) |=>
		status_o.c == $past(status_o.c) && status_o.ov == $past(status_o.ov) &&
		status_o.z == ($past(mem_rd_data_i) == 8'h00))
		else $error("move file flags wrong");
	a_ff_source: assert property ( // [RULE7]
		s_ff_first |=> mem_rd_o && mem_addr_o == $past(instr_i[11:0]))
		else $error("file move source address wrong");
	a_ff_order: assert property ( // [RULE8]
		s_ff_second |=> (mem_rd_o && !mem_wr_o && mem_addr_o == $past(instr_i[11:0]))
		##1 (mem_wr_o && $stable(mem_addr_o)))
		else $error("file move dummy read then write broken");
	a_bank_load: assert property ( // [RULE11]
		(go && op_in == CIME_OP_BANKLD) |=> bank_o == $past(instr_i[7:0]) &&
		$stable(status_o) && instr_ready_o)
		else $error("bank load wrong");
	a_or_literal: assert property ( // [RULE12]
		(go && op_in == CIME_OP_ORL) |=> wreg_o == ($past(wreg_o) | $past(instr_i[7:0]))
		&& status_o.c == $past(status_o.c))
		else $error("or literal wrong");
	a_lit_move: assert property ( // [RULE13]
		(go && op_in == CIME_OP_LITW) |=> wreg_o == $past(instr_i[7:0]) &&
		$stable(status_o) && done_o && instr_ready_o)
		else $error("literal move wrong");

endmodule : cime_exec

`default_nettype wire

// File: design/cime_pkg.sv
// Package: constants, types and decode helpers for the increment/move executor
//
// Notes on behaviour
// [RULE1] Increment file adds one; d picks W or file; updates C, DC, N, OV, Z.
// [RULE2] Access bit 0 uses fixed access bank; 1 uses bank select register bank.
// [RULE3] Skip ops: one cycle if no skip; skip discards next word, two words if long. Here they take three clocks (fetch, read, execute), skip or not.
// [RULE4] Load pointer: first cycle writes literal upper part to pointer high byte.
// [RULE5] Load pointer: second cycle writes second word's low byte to pointer low byte.
// [RULE6] Move file copies file to W or file; only N and Z change.
// [RULE7] File-to-file move takes 12-bit source and 12-bit destination addresses.
// [RULE8] File-to-file move reads source, then dummy reads and writes destination.
// [RULE9] Software must not target program counter low or stack top bytes.
// [RULE10] Software should not alter interrupt setup by file-to-file move while enabled.
// [RULE11] Load bank writes full 8-bit literal to bank select, one cycle, no flags.
// [RULE12] OR literal and OR file combine with W; only N and Z change.
// [RULE13] Literal-to-W and W-to-file moves take one cycle, flags unchanged.
`default_nettype none

package cime_pkg;

	// ----------------------------------------------------------------
	// Widths and fields
	// ----------------------------------------------------------------
	localparam int            CIME_ADDR_W   = 12;
	localparam int            CIME_DATA_W   = 8;
	localparam int            CIME_WORD_W   = 16;
	localparam int            CIME_PTR_N    = 3;
	localparam int            CIME_D_BIT    = 9;
	localparam int            CIME_A_BIT    = 8;
	localparam logic [7:0]    CIME_ACC_SPLIT = 8'h80;
	localparam logic [3:0]    CIME_ACC_LO_BANK = 4'h0;
	localparam logic [3:0]    CIME_ACC_HI_BANK = 4'hf;

	// ----------------------------------------------------------------
	// Opcode patterns
	// ----------------------------------------------------------------
	localparam logic [5:0]    CIME_OPC_INC    = 6'h0a;
	localparam logic [5:0]    CIME_OPC_INCSZ  = 6'h0f;
	localparam logic [5:0]    CIME_OPC_INSNZ  = 6'h12;
	localparam logic [5:0]    CIME_OPC_ORF    = 6'h04;
	localparam logic [5:0]    CIME_OPC_FMOVE  = 6'h14;
	localparam logic [6:0]    CIME_OPC_WSTORE = 7'h37;
	localparam logic [7:0]    CIME_OPC_ORL    = 8'h09;
	localparam logic [7:0]    CIME_OPC_BANKLD = 8'h01;
	localparam logic [7:0]    CIME_OPC_LITW   = 8'h0e;
	localparam logic [9:0]    CIME_OPC_PTRLD  = 10'h3b8;
	localparam logic [3:0]    CIME_OPC_F2F    = 4'hc;
	localparam logic [5:0]    CIME_OPC_LONG   = 6'h3b;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic n;
		logic ov;
		logic z;
		logic dc;
		logic c;
	} cime_flags_t;

	typedef enum logic [5:0] {
		CIME_S_FETCH = 6'b000001,
		CIME_S_READ  = 6'b000010,
		CIME_S_EXEC  = 6'b000100,
		CIME_S_FFRD  = 6'b001000,
		CIME_S_WORD2 = 6'b010000,
		CIME_S_FFWR  = 6'b100000
	} cime_state_t;

	typedef enum logic [3:0] {
		CIME_OP_NOP, CIME_OP_INC, CIME_OP_INCSZ, CIME_OP_INSNZ, CIME_OP_ORF,
		CIME_OP_FMOVE, CIME_OP_WSTORE, CIME_OP_ORL, CIME_OP_BANKLD, CIME_OP_LITW,
		CIME_OP_PTRLD, CIME_OP_F2F
	} cime_op_t;

	// ----------------------------------------------------------------
	// Decode helpers
	// ----------------------------------------------------------------
	function automatic cime_op_t cime_decode(input logic [15:0] w);
		cime_op_t op;
		op = CIME_OP_NOP;
		if (w[15:10] == CIME_OPC_INC) op = CIME_OP_INC;
		else if (w[15:10] == CIME_OPC_INCSZ) op = CIME_OP_INCSZ;
		else if (w[15:10] == CIME_OPC_INSNZ) op = CIME_OP_INSNZ;
		else if (w[15:10] == CIME_OPC_ORF) op = CIME_OP_ORF;
		else if (w[15:10] == CIME_OPC_FMOVE) op = CIME_OP_FMOVE;
		else if (w[15:9] == CIME_OPC_WSTORE) op = CIME_OP_WSTORE;
		else if (w[15:8] == CIME_OPC_ORL) op = CIME_OP_ORL;
		else if (w[15:8] == CIME_OPC_BANKLD) op = CIME_OP_BANKLD;
		else if (w[15:8] == CIME_OPC_LITW) op = CIME_OP_LITW;
		else if (w[15:6] == CIME_OPC_PTRLD) op = CIME_OP_PTRLD;
		else if (w[15:12] == CIME_OPC_F2F) op = CIME_OP_F2F;
		return op;
	endfunction : cime_decode

	// First word of any two-word instruction
	function automatic logic cime_is_long(input logic [15:0] w);
		return (w[15:12] == CIME_OPC_F2F) || (w[15:10] == CIME_OPC_LONG);
	endfunction : cime_is_long

	function automatic logic [11:0] cime_file_addr(input logic [15:0] w,
		input logic [7:0] bank_sel);
		logic [3:0] bank;
		bank = (w[7:0] < CIME_ACC_SPLIT) ? CIME_ACC_LO_BANK : CIME_ACC_HI_BANK;
		if (w[CIME_A_BIT])
			bank = bank_sel[3:0];
		return {bank, w[7:0]};
	endfunction : cime_file_addr

endpackage : cime_pkg

`default_nettype wire

// File: design/cime_alu.sv
// Arithmetic unit: increment, OR and pass-through with status flags
`default_nettype none

module cime_alu
	import cime_pkg::*;
(
	// Operation
	input  wire logic        [3:0] op_i,
	// Operands
	input  wire logic        [7:0] w_i,
	input  wire logic        [7:0] f_i,
	// Result
	output logic             [7:0] res_o,
	output cime_flags_t            flags_o
);

	logic [8:0] sum;
	logic [4:0] nib;

	always_comb begin
		sum     = {1'b0, f_i} + 9'h001;
		nib     = {1'b0, f_i[3:0]} + 5'h01;
		flags_o = '0;
		case (cime_op_t'(op_i))
			CIME_OP_INC, CIME_OP_INCSZ, CIME_OP_INSNZ: begin
				res_o      = sum[7:0];
				flags_o.c  = sum[8];
				flags_o.dc = nib[4];
				flags_o.ov = (f_i == 8'h7f);
			end
			CIME_OP_ORF:
				res_o = w_i | f_i;
			default:
				res_o = f_i;
		endcase
		flags_o.n = res_o[7];
		flags_o.z = (res_o == 8'h00);
	end

endmodule : cime_alu

`default_nettype wire

// File: test/cime_mem_model.sv
// Data memory model facing the executor's memory port
`default_nettype none

module cime_mem_model (
	// Clock
	input  wire logic        clk_i,
	// Access from the executor
	input  wire logic [11:0] mem_addr_i,
	input  wire logic        mem_rd_i,
	input  wire logic        mem_wr_i,
	input  wire logic [7:0]  mem_wr_data_i,
	// Read answer
	output logic      [7:0]  rd_data_o
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [7:0]  store [0:4095];
	logic [7:0]  rd_q         = 8'h00;
	logic [11:0] last_rd      = 12'h000;
	logic [11:0] rd_before_wr = 12'h000;

	assign rd_data_o = rd_q;

	initial begin
		for (int i = 0; i < 4096; i++) store[i] = 8'h00;
	end

	// Whole 12-bit space decoded
	// Data valid only in the cycle after a read, toggling otherwise so stale data shows
	always @(posedge clk_i) begin
		if (mem_rd_i) begin
			rd_q <= store[mem_addr_i];
			last_rd <= mem_addr_i;
		end else begin
			rd_q <= ~rd_q;
		end
		if (mem_wr_i) begin
			store[mem_addr_i] <= mem_wr_data_i;
			rd_before_wr <= last_rd;
		end
	end
endmodule : cime_mem_model

`default_nettype wire

// File: test/tb_top.sv
// Self-checking bench for the increment and move executor
`default_nettype none

module tb_top import cime_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ns;

	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        valid = 1'b0;
	logic [15:0] instr = 16'h0000;
	logic        ready, rd, wr, discard, done;
	logic [11:0] addr;
	logic [7:0]  rdata, wdata, wreg, bank;
	cime_flags_t status;
	logic [35:0] ptr;
	int          n_mismatch = 0;
	int          checks_done = 0;
	int          n_discard = 0;
	logic [15:0] mw_word [3] = '{16'h6f10, 16'h6e10, 16'h6e90};
	logic [11:0] mw_addr [3] = '{12'h510, 12'h010, 12'hf90};
	logic [15:0] lf_w1 [2] = '{16'hee23, 16'hee0f};
	logic [15:0] lf_w2 [2] = '{16'hf0ab, 16'hf0ff};
	logic [11:0] lf_k [2] = '{12'h3ab, 12'hfff};
	int          lf_g [2] = '{2, 0};

	cime_exec dut (
		.clk_i(clk_i), .rst_i(rst_i), .instr_valid_i(valid), .instr_i(instr),
		.instr_ready_o(ready), .mem_addr_o(addr), .mem_rd_o(rd), .mem_rd_data_i(rdata),
		.mem_wr_o(wr), .mem_wr_data_o(wdata), .wreg_o(wreg), .bank_o(bank),
		.status_o(status), .ptr_o(ptr), .discard_o(discard), .done_o(done)
	);

	cime_mem_model mem (
		.clk_i(clk_i), .mem_addr_i(addr), .mem_rd_i(rd), .mem_wr_i(wr),
		.mem_wr_data_i(wdata), .rd_data_o(rdata)
	);

	initial begin
		forever #25 clk_i = ~clk_i;
	end

	always @(posedge clk_i) begin
		if (discard === 1'b1) n_discard++;
	end

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// Word stays offered until a falling edge shows ready, then is taken at the next rise
	task automatic send(input logic [15:0] w);
		int n;
		@(negedge clk_i);
		valid = 1'b1;
		instr = w;
		n = 0;
		while (ready !== 1'b1 && n < 20) begin
			@(negedge clk_i);
			n++;
		end
		if (n == 20) n_mismatch++;
		@(posedge clk_i);
	endtask : send

	task automatic idle();
		@(negedge clk_i);
		valid = 1'b0;
	endtask : idle

	// Extra edge lets the write strobe's effect land in the memory model
	task automatic wait_done();
		int n;
		n = 0;
		while (done !== 1'b1 && n < 20) begin
			@(negedge clk_i);
			n++;
		end
		if (n == 20) n_mismatch++;
		@(negedge clk_i);
	endtask : wait_done

	task automatic tally_and_finish();
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : tally_and_finish

	initial begin
		#400000;
		n_mismatch++;
		tally_and_finish();
	end

	initial begin
		repeat (6) @(negedge clk_i);
		chk("rst_state", 16'h0000, {15'h0000, ready} | {wreg, bank} | {11'h000, status});
		chk("rst_ptr", 16'h0000, {4'h0, ptr[35:24] | ptr[23:12] | ptr[11:0]});
		rst_i = 1'b0;
		@(negedge clk_i);
		chk("ready", 16'h0001, {15'h0000, ready});
		// Back-to-back literal ops
		send(16'h0e9a);
		send(16'h0935);
		idle();
		chk("wreg", 16'h00bf, {8'h00, wreg});
		chk("status", 16'h0010, {11'h000, status});
		send(16'h0e00);
		send(16'h0900);
		send(16'h0e80);
		idle();
		chk("wreg", 16'h0080, {8'h00, wreg});
		chk("status", 16'h0004, {11'h000, status});
		send(16'h0125);
		idle();
		chk("bank", 16'h0025, {8'h00, bank});
		chk("status", 16'h0004, {11'h000, status});
		// Banked, low access and high access stores of W
		for (int i = 0; i < 3; i++) begin
			send(mw_word[i]);
			idle();
			repeat (2) @(negedge clk_i);
			chk("mem_acc_to_file_op", 16'h0080, {8'h00, mem.store[mw_addr[i]]});
		end
		chk("status", 16'h0004, {11'h000, status});
		mem.store[12'h020] = 8'h7f;
		mem.store[12'h540] = 8'hff;
		mem.store[12'h022] = 8'h05;
		send(16'h2a20);
		idle();
		wait_done();
		chk("mem_inc", 16'h0080, {8'h00, mem.store[12'h020]});
		chk("status", 16'h001a, {11'h000, status});
		send(16'h2940);
		idle();
		wait_done();
		chk("wreg", 16'h0000, {8'h00, wreg});
		chk("mem_keep", 16'h00ff, {8'h00, mem.store[12'h540]});
		chk("status", 16'h0007, {11'h000, status});
		send(16'h5020);
		idle();
		wait_done();
		chk("wreg", 16'h0080, {8'h00, wreg});
		chk("status", 16'h0013, {11'h000, status});
		send(16'h5291);
		idle();
		wait_done();
		chk("status", 16'h0007, {11'h000, status});
		send(16'h1222);
		idle();
		wait_done();
		chk("mem_or", 16'h0085, {8'h00, mem.store[12'h022]});
		chk("status", 16'h0013, {11'h000, status});
		// Skip, no skip, and skip over a two-word move
		mem.store[12'h023] = 8'hff;
		mem.store[12'h024] = 8'h05;
		mem.store[12'h025] = 8'h05;
		send(16'h3e23);
		send(16'h0e11);
		send(16'h3e24);
		send(16'h0e33);
		idle();
		repeat (4) @(negedge clk_i);
		chk("wreg", 16'h0033, {8'h00, wreg});
		chk("discards", 16'h0001, n_discard[15:0]);
		send(16'h4a25);
		send(16'hc020);
		send(16'hf030);
		send(16'h0e44);
		idle();
		repeat (4) @(negedge clk_i);
		chk("discards", 16'h0003, n_discard[15:0]);
		chk("mem_skip", 16'h0000, {8'h00, mem.store[12'h030]});
		chk("wreg", 16'h0044, {8'h00, wreg});
		for (int i = 0; i < 2; i++) begin
			send(lf_w1[i]);
			idle();
			chk("ptr_hi", {4'h0, lf_k[i][11:8], 8'h00}, {4'h0, ptr[lf_g[i]*12 +: 12]});
			send(lf_w2[i]);
			idle();
			chk("ptr", {4'h0, lf_k[i]}, {4'h0, ptr[lf_g[i]*12 +: 12]});
		end
		// Destination kept clear of program counter and stack bytes
		// No interrupt setup is touched by the move
		mem.store[12'habc] = 8'h5e;
		send(16'hcabc);
		send(16'hf123);
		idle();
		wait_done();
		chk("mem_ff", 16'h005e, {8'h00, mem.store[12'h123]});
		chk("dummy_rd", 16'h0123, {4'h0, mem.rd_before_wr});
		tally_and_finish();
	end
endmodule : tb_top

`default_nettype wire
